// [hdl/xctc_regs.svh]
// register map, field positions, reset values and table constants of the rate compensation fifo
`ifndef XCTC_REGS_SVH
`define XCTC_REGS_SVH

// register byte offsets
`define XCTC_CTRL_OFS    8'h00
`define XCTC_STAT_OFS    8'h04

// control register fields: receive direction in the low byte, transmit in the next
`define XCTC_RX_DSEL_LSB 0
`define XCTC_RX_WSEL_LSB 3
`define XCTC_TX_DSEL_LSB 8
`define XCTC_TX_WSEL_LSB 11
`define XCTC_SEQ_DEL_BIT 16
`define XCTC_CTRL_RST    32'h0000_1c1c
`define XCTC_CTRL_MASK   32'h0001_1f1f

// status register fields
`define XCTC_ST_OVF_BIT  0
`define XCTC_ST_UNF_BIT  1
`define XCTC_ST_DEL_BIT  2
`define XCTC_ST_INS_BIT  3
`define XCTC_ST_FILL_LSB 8

// gap rule and column size in characters
`define XCTC_MIN_IPG     6'd5
`define XCTC_COL_CHARS   6'd4
`define XCTC_GAP_MAX     6'h3f

// control character codes
`define XCTC_CH_IDLE     8'h07
`define XCTC_CH_IDLE_K   8'hbc
`define XCTC_CH_IDLE_A   8'h7c
`define XCTC_CH_IDLE_R   8'h1c
`define XCTC_CH_SEQ      8'h9c
`define XCTC_CH_START    8'hfb
`define XCTC_CH_TERM     8'hfd

// depth codes and {depth, low, high} thresholds per depth / watermark selection
`define XCTC_DSEL_PLAIN  3'b000
`define XCTC_DSEL_12     3'b001
`define XCTC_DSEL_16     3'b010
`define XCTC_DSEL_24     3'b011
`define XCTC_T32_11      {6'd32, 6'd15, 6'd18}
`define XCTC_T32_10      {6'd32, 6'd13, 6'd20}
`define XCTC_T32_01      {6'd32, 6'd10, 6'd23}
`define XCTC_T32_00      {6'd32, 6'd6,  6'd27}
`define XCTC_T24_1X      {6'd24, 6'd9,  6'd14}
`define XCTC_T24_01      {6'd24, 6'd6,  6'd17}
`define XCTC_T24_00      {6'd24, 6'd5,  6'd19}
`define XCTC_T16_1X      {6'd16, 6'd7,  6'd10}
`define XCTC_T16_0X      {6'd16, 6'd5,  6'd12}
`define XCTC_T12         {6'd12, 6'd4,  6'd7}
`define XCTC_T8          {6'd8,  6'd0,  6'd8}

`endif

// [hdl/xctc_pkg.sv]
// types shared by the rate compensation fifo
package xctc_pkg;
  // one lane: error flag, control flag, character
  typedef struct packed {
    logic       err;
    logic       ctrl;
    logic [7:0] data;
  } xctc_lane_s;
  // one 40-bit column, lane 0 first on the wire
  typedef struct packed {
    xctc_lane_s [3:0] lane;
  } xctc_col_s;
  // selected size and thresholds
  typedef struct packed {
    logic [5:0] depth;
    logic [5:0] low;
    logic [5:0] high;
  } xctc_cfg_s;
  // ahb-lite address phase as seen by the slave
  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic [1:0]  trans;
    logic        write;
    logic [2:0]  size;
  } xctc_ahb_s;
endpackage : xctc_pkg

// [hdl/xctc_fifo.sv]
// rate compensation fifo with ahb-lite control and status registers
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "xctc_regs.svh"
//
// Summary of operation
// - storage of 32 columns, 40 bits each
// - receive and transmit depth fields kept separately
// - delete idle, insert idle, optionally delete sequence
// - insert and delete whole four-character columns only
// - insert only after idle or sequence column
// - never insert while a packet is passing
// - idle deletion keeps gap at five characters minimum
// - first idle column after terminate kept
// - of two back-to-back sequence columns delete one
// - read side inserts from low watermark until above midpoint
// - write side drops from high watermark until below midpoint
// - one column written per cycle unless dropped
// - one column read per cycle unless inserting
// - depth and watermark selectors share one register
// - overflow or underflow flags error, restarts fifo
// - error flags sticky, cleared by status read
// - top depth bit gives 32 deep, 01 gives 10/23
// - codes 011, 010, 001 give 24, 16, 12 deep
// - code 000 plain 8 deep, no compensation
module xctc_fifo
  import xctc_pkg::*;
#(
  parameter bit IS_TX     = 1'b0,
  parameter int DEPTH_MAX = 32
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // column stream in
  input  wire logic        in_valid,
  input  wire xctc_col_s   in_col,
  // column stream out
  input  wire logic        out_ready,
  output logic             out_valid,
  output xctc_col_s        out_col
);

  localparam int PW = $clog2(DEPTH_MAX);

  // column classification helpers
  function automatic logic is_idle_char(input xctc_lane_s l);
    return l.ctrl & ((l.data == `XCTC_CH_IDLE) | (l.data == `XCTC_CH_IDLE_K) |
                     (l.data == `XCTC_CH_IDLE_A) | (l.data == `XCTC_CH_IDLE_R));
  endfunction : is_idle_char

  function automatic logic is_idle_col(input xctc_col_s c);
    return is_idle_char(c.lane[0]) & is_idle_char(c.lane[1]) &
           is_idle_char(c.lane[2]) & is_idle_char(c.lane[3]);
  endfunction : is_idle_col

  function automatic logic is_seq_col(input xctc_col_s c);
    return c.lane[0].ctrl & (c.lane[0].data == `XCTC_CH_SEQ);
  endfunction : is_seq_col

  function automatic logic is_start_col(input xctc_col_s c);
    return c.lane[0].ctrl & (c.lane[0].data == `XCTC_CH_START);
  endfunction : is_start_col

  // characters from the terminate to the column end, zero when none
  function automatic logic [5:0] term_chars(input xctc_col_s c);
    logic [5:0] n;
    n = 6'd0;
    for (int k = 3; k >= 0; k--) begin
      if (c.lane[k].ctrl && c.lane[k].data == `XCTC_CH_TERM) begin
        n = `XCTC_COL_CHARS - 6'(k);
      end
    end
    return n;
  endfunction : term_chars

  // size and thresholds from the depth and watermark selectors
  function automatic xctc_cfg_s cfg_of(input logic [2:0] dsel, input logic [1:0] wsel);
    xctc_cfg_s c;
    c = `XCTC_T8;
    if (dsel[2]) begin
      unique case (wsel)
        2'b11:   c = `XCTC_T32_11;
        2'b10:   c = `XCTC_T32_10;
        2'b01:   c = `XCTC_T32_01;
        default: c = `XCTC_T32_00;
      endcase
    end else if (dsel == `XCTC_DSEL_24) begin
      c = wsel[1] ? `XCTC_T24_1X : (wsel[0] ? `XCTC_T24_01 : `XCTC_T24_00);
    end else if (dsel == `XCTC_DSEL_16) begin
      c = wsel[1] ? `XCTC_T16_1X : `XCTC_T16_0X;
    end else if (dsel == `XCTC_DSEL_12) begin
      c = `XCTC_T12;
    end
    return c;
  endfunction : cfg_of

  localparam xctc_col_s IDLE_COL = {4{1'b0, 1'b1, `XCTC_CH_IDLE}};

  // state
  logic [31:0]     ctrl_q;
  logic            ovf_q, unf_q;
  xctc_ahb_s       aph_q;
  logic [31:0]     hrdata_q;
  localparam int WIDTH_C = $bits(xctc_col_s);
  logic [WIDTH_C-1:0] mem [DEPTH_MAX];
  logic [PW-1:0]   wr_idx_q, rd_idx_q;
  logic [5:0]      count_q, count_d;
  logic            del_mode_q, ins_mode_q;
  logic            pkt_q, first_after_t_q, prev_seq_q;
  logic [5:0]      gap_q, gap_d;
  logic            rd_pkt_q, last_gapish_q;
  logic            out_valid_q;
  xctc_col_s       out_col_q;

  // active configuration: each direction owns its own selector pair
  wire logic [2:0] dsel    = IS_TX ? ctrl_q[`XCTC_TX_DSEL_LSB +: 3] : ctrl_q[`XCTC_RX_DSEL_LSB +: 3];
  wire logic [1:0] wsel    = IS_TX ? ctrl_q[`XCTC_TX_WSEL_LSB +: 2] : ctrl_q[`XCTC_RX_WSEL_LSB +: 2];
  wire xctc_cfg_s  cfg     = cfg_of(dsel, wsel);
  wire logic       ctc_on  = (dsel != `XCTC_DSEL_PLAIN);
  wire logic       seq_en  = ctrl_q[`XCTC_SEQ_DEL_BIT];
  wire logic [5:0] mid     = {1'b0, cfg.depth[5:1]};

  // write side classification
  wire logic       in_idle = is_idle_col(in_col);
  wire logic       in_seq  = is_seq_col(in_col);
  wire logic [5:0] in_term = term_chars(in_col);
  wire logic       gap_ok  = (gap_q >= `XCTC_MIN_IPG);

  // whole idle columns only, never the first after a terminate, never inside a packet
  wire logic del_idle = in_idle & !first_after_t_q & gap_ok;
  // second of a back-to-back sequence pair, only when software allows it
  wire logic del_seq  = in_seq & seq_en & prev_seq_q;
  wire logic drop     = in_valid & ctc_on & del_mode_q & !pkt_q & (del_idle | del_seq);
  wire logic do_wr    = in_valid & !drop;

  // read side: insert an idle column only behind idle or sequence, out of packets
  wire logic ins_now  = out_ready & ctc_on & ins_mode_q & last_gapish_q & !rd_pkt_q;
  wire logic rd_try   = out_ready & !ins_now;
  wire logic unf      = rd_try & (count_q == 6'd0);
  wire logic do_rd    = rd_try & !unf;
  wire logic ovf      = do_wr & (count_q >= cfg.depth) & !do_rd;
  wire logic err      = ovf | unf;
  wire logic do_wr_ok = do_wr & !ovf;

  wire logic [PW-1:0] wr_nxt = (6'(wr_idx_q) >= cfg.depth - 6'd1) ? '0 : wr_idx_q + PW'(1);
  wire logic [PW-1:0] rd_nxt = (6'(rd_idx_q) >= cfg.depth - 6'd1) ? '0 : rd_idx_q + PW'(1);
  wire xctc_col_s     rd_col = xctc_col_s'(mem[rd_idx_q]);
  wire xctc_col_s     emit   = do_rd ? rd_col : IDLE_COL;

  // fill level follows accepted writes and reads
  assign count_d = count_q + 6'(do_wr_ok) - 6'(do_rd);

  // gap counter: characters since the last terminate that actually went into the fifo
  always_comb begin
    gap_d = gap_q;
    if (in_valid) begin
      if (in_term != 6'd0) begin
        gap_d = in_term;
      end else if (is_start_col(in_col) || (!in_idle && !in_seq)) begin
        gap_d = 6'd0;
      end else if (do_wr && gap_q <= `XCTC_GAP_MAX - `XCTC_COL_CHARS) begin
        gap_d = gap_q + `XCTC_COL_CHARS;
      end
    end
  end

  // storage array; no reset since contents are qualified by the pointers
  always_ff @(posedge hclk) begin
    if (do_wr_ok) begin
      mem[wr_idx_q] <= in_col;
    end
  end

  // pointers and fill level; an error restarts them half full
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_idx_q <= '0;
      rd_idx_q <= '0;
      count_q  <= 6'd0;
    end else if (err) begin
      wr_idx_q <= PW'(mid);
      rd_idx_q <= '0;
      count_q  <= mid;
    end else begin
      wr_idx_q <= do_wr_ok ? wr_nxt : wr_idx_q;
      rd_idx_q <= do_rd ? rd_nxt : rd_idx_q;
      count_q  <= count_d;
    end
  end

  // watermark hysteresis: the midpoint band keeps the modes from chattering
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      del_mode_q <= 1'b0;
      ins_mode_q <= 1'b0;
    end else if (err || !ctc_on) begin
      del_mode_q <= 1'b0;
      ins_mode_q <= 1'b0;
    end else begin
      del_mode_q <= (count_q >= cfg.high) | (del_mode_q & (count_q >= mid));
      ins_mode_q <= (count_q <= cfg.low) | (ins_mode_q & (count_q <= mid));
    end
  end

  // write side stream tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_q           <= 1'b0;
      first_after_t_q <= 1'b0;
      prev_seq_q      <= 1'b0;
      gap_q           <= 6'd0;
    end else if (in_valid) begin
      pkt_q           <= (in_term != 6'd0) ? 1'b0 : (pkt_q | is_start_col(in_col));
      first_after_t_q <= (in_term != 6'd0);
      prev_seq_q      <= in_seq & do_wr; // a deleted one cannot pair again
      gap_q           <= gap_d;
    end
  end

  // read side stream tracking and output column
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pkt_q      <= 1'b0;
      last_gapish_q <= 1'b0;
      out_valid_q   <= 1'b0;
      out_col_q     <= '0;
    end else begin
      out_valid_q <= out_ready;
      if (out_ready) begin
        out_col_q     <= emit;
        last_gapish_q <= is_idle_col(emit) | is_seq_col(emit);
        rd_pkt_q      <= (term_chars(emit) != 6'd0) ? 1'b0 : (rd_pkt_q | is_start_col(emit));
      end
    end
  end

  // ahb-lite decode; the slave never stalls and always answers okay
  wire logic       aph_go   = hsel & htrans[1] & hready;
  wire logic       is_ctrl  = (haddr[7:0] == `XCTC_CTRL_OFS);
  wire logic       is_stat  = (haddr[7:0] == `XCTC_STAT_OFS);
  wire logic       stat_rd  = aph_go & !hwrite & is_stat;
  wire logic       ctrl_wr  = aph_q.sel & aph_q.write & (aph_q.addr[7:0] == `XCTC_CTRL_OFS);
  wire logic [31:0] stat_v  = {16'h0000, 2'b00, count_q, 4'h0, ins_mode_q, del_mode_q, unf_q, ovf_q};
  wire logic [31:0] rd_v    = is_ctrl ? ctrl_q : (is_stat ? stat_v : 32'h0000_0000);

  // address phase capture and read data; unmapped offsets in the low address byte read zero, upper address bits are not decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q    <= '0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      aph_q    <= aph_go ? {1'b1, haddr, htrans, hwrite, hsize} : '0;
      hrdata_q <= (aph_go && !hwrite) ? rd_v : hrdata_q;
    end
  end

  // control register: written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `XCTC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= hwdata & `XCTC_CTRL_MASK;
    end
  end

  // sticky error flags: a new event in the reading cycle wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= ovf | (ovf_q & !stat_rd);
      unf_q <= unf | (unf_q & !stat_rd);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign out_valid = out_valid_q;
  assign out_col   = out_col_q;

  // checks
  fill_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count_q <= 6'(DEPTH_MAX)) else $error("fill level above storage size");
  depth32_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dsel[2] && wsel == 2'b01) |-> (cfg.depth == 6'd32 && cfg.low == 6'd10 && cfg.high == 6'd23))
    else $error("32 deep watermark pair wrong");
  plain_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dsel == `XCTC_DSEL_PLAIN) |-> (!drop && !ins_now && cfg.depth == 6'd8)) else $error("plain fifo compensates");
  first_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (in_valid && first_after_t_q && in_idle) |-> do_wr) else $error("first idle after terminate dropped");
  gap_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (drop && in_idle) |-> (gap_q >= 6'd5)) else $error("gap cut below five");
  seq_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (drop && in_seq) |=> !(drop && in_seq)) else $error("both sequence columns deleted");
  ins_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ins_now && !err) |=> (out_valid && out_col == IDLE_COL && $stable(rd_idx_q)))
    else $error("insertion not an idle column");
  ins_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctc_on && count_q <= cfg.low && !err) |=> ins_mode_q) else $error("insertion not triggered");
  del_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (del_mode_q && ctc_on && !err && count_q >= mid) |=> del_mode_q) else $error("deletion left too early");
  err_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    err |=> (count_q == $past(mid) && (ovf_q || unf_q))) else $error("error did not restart at midpoint");
  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_rd && !ovf) |=> !ovf_q) else $error("overflow flag not cleared by read");
  no_pkt_ins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pkt_q |-> !ins_now) else $error("insertion inside packet");

  ins_seen_c:  cover property (@(posedge hclk) disable iff (!hresetn) ins_now ##1 ins_now);
  del_seen_c:  cover property (@(posedge hclk) disable iff (!hresetn) drop && in_idle);
  seq_del_c:   cover property (@(posedge hclk) disable iff (!hresetn) drop && in_seq);
  ovf_seen_c:  cover property (@(posedge hclk) disable iff (!hresetn) ovf ##1 stat_rd);

endmodule : xctc_fifo

// [tb/xctc_link_model.sv]
// link partner model that feeds columns into the rate compensation fifo
`timescale 1ns/1ns
module xctc_link_model
  import xctc_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // request from the bench
  input  wire logic      go,
  input  wire xctc_col_s col,
  // column stream into the fifo
  output logic           in_valid,
  output xctc_col_s      in_col
);
  // a released bus shows the inverse of its last value so stale data never passes for a column
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_valid <= 1'b0;
      in_col   <= '0;
    end else begin
      in_valid <= go;  // one column a cycle, back to back
      in_col   <= go ? col : ~in_col;
    end
  end
endmodule : xctc_link_model

// [tb/xctc_fifo_bench.sv]
// self-checking bench for the rate compensation fifo
`timescale 1ns/1ns
`include "xctc_regs.svh"
module xctc_fifo_bench
  import xctc_pkg::*;
;
  localparam logic [31:0] A_CTRL = {24'h0, `XCTC_CTRL_OFS};
  localparam logic [31:0] A_STAT = {24'h0, `XCTC_STAT_OFS};
  // bus, stream and bookkeeping signals
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        go = 1'b0;
  xctc_col_s   col_req = '0;
  logic        in_valid;
  xctc_col_s   in_col;
  logic        out_ready = 1'b0;
  logic        out_valid;
  xctc_col_s   out_col;
  int          n_errors = 0;
  int          tests_run = 0;
  xctc_col_s   got[$];

  // the single slave drives the bus ready
  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  // every column answered by the fifo is collected in order
  always @(posedge hclk) begin
    if (out_valid === 1'b1) got.push_back(out_col);
  end

  function automatic xctc_col_s mk(input logic [9:0] l0, input logic [9:0] lr);
    return {lr, lr, lr, l0};
  endfunction : mk
  function automatic xctc_col_s dat(input logic [7:0] b);
    return mk({2'b00, b}, {2'b00, b});
  endfunction : dat
  function automatic logic [31:0] stat(input logic [5:0] f, input logic [3:0] b);
    return {18'h0, f, 4'h0, b};
  endfunction : stat

  task check(input logic [39:0] act, input logic [39:0] exp);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : check

  // one single ahb-lite transfer; read data is taken at the data phase edge
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr_reg
  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check({8'h0, r}, {8'h0, exp});
    check({39'h0, hresp}, 40'h0);
  endtask : rd_chk

  // stream tasks: columns go out back to back until idle_in releases the link
  task send(input xctc_col_s c);
    @(posedge hclk);
    go      <= 1'b1;
    col_req <= c;
  endtask : send
  task idle_in();
    @(posedge hclk);
    go <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : idle_in
  task pull(input int n);
    repeat (n) begin
      @(posedge hclk);
      out_ready <= 1'b1;
    end
    @(posedge hclk);
    out_ready <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : pull

  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // main sequence
  initial begin
    xctc_col_s idl;
    int        i;
    idl = mk(10'h107, 10'h107);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // register map, reset values and depth codes
    rd_chk(A_CTRL, `XCTC_CTRL_RST);
    // reset config is 32 deep with an empty fifo, so insertion mode is already armed
    rd_chk(A_STAT, stat(6'd0, 4'b1000));
    rd_chk(32'h0000_0008, 32'h0);
    wr_reg(A_CTRL, 32'hffff_ffff);
    rd_chk(A_CTRL, `XCTC_CTRL_MASK);
    for (i = 0; i < 8; i++) begin
      wr_reg(A_CTRL, {8'h0, 8'h01, 3'h0, 2'(i), 3'(i), 3'h0, 2'(i), 3'(i)});
      rd_chk(A_CTRL, {8'h0, 8'h01, 3'h0, 2'(i), 3'(i), 3'h0, 2'(i), 3'(i)});
      // empty fifo: every compensating depth arms insertion, the plain one never does
      rd_chk(A_STAT, stat(6'd0, {(i != 0), 3'b000}));
    end
    $display("test 1 registers done");
    // 32 deep with 10/23 marks and sequence deletion on; fill past the high mark
    wr_reg(A_CTRL, 32'h0001_1c0c);
    send(mk(10'h1fb, 10'h000));
    for (i = 1; i < 23; i++) send(dat(8'(i)));
    send(mk(10'h1fd, 10'h107));
    repeat (3) send(idl);
    repeat (2) send(mk(10'h19c, 10'h000));
    idle_in();
    rd_chk(A_STAT, stat(6'd26, 4'b0100));
    $display("test 2 deletion done");
    // drain: packet passes whole, then its stored idle column, then idle columns are made up without reading
    pull(28);
    check(40'(got.size()), 40'd28);
    check(got[0], mk(10'h1fb, 10'h000));
    for (i = 1; i < 23; i++) check(got[i], dat(8'(i)));
    check(got[23], mk(10'h1fd, 10'h107));
    check(got[24], idl);
    for (i = 25; i < 28; i++) check(got[i], idl);
    rd_chk(A_STAT, stat(6'd1, 4'b1000));
    $display("test 3 insertion done");
    // overflow: data columns are never dropped, the 33rd entry overflows
    got.delete();
    for (i = 0; i < 32; i++) send(dat(8'(8'h40 + i)));
    idle_in();
    rd_chk(A_STAT, stat(6'd16, 4'b0001));
    rd_chk(A_STAT, stat(6'd16, 4'b0000));
    $display("test 4 overflow done");
    // underflow: sixteen stale entries from the read start, then an empty read
    pull(17);
    for (i = 0; i < 16; i++) check(got[i], dat(8'(8'h46 + i)));
    check(got[16], idl);
    rd_chk(A_STAT, stat(6'd16, 4'b0010));
    $display("test 5 underflow done");
    give_verdict();
  end

  // design and link partner
  xctc_link_model u_link (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .go       (go),
    .col      (col_req),
    .in_valid (in_valid),
    .in_col   (in_col)
  );
  xctc_fifo #(.IS_TX(1'b0), .DEPTH_MAX(32)) u_dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .in_valid  (in_valid),
    .in_col    (in_col),
    .out_ready (out_ready),
    .out_valid (out_valid),
    .out_col   (out_col)
  );
endmodule : xctc_fifo_bench
